/* File: rtl/pmpl_pkg.sv */
// Constants, register map and types of the power management pin logic.
// Assumes a single 50 MHz system clock and an Avalon-MM register port.
package pmpl_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ         = 50_000_000;
  localparam int WAKE_PULSE_MS  = 50;
  localparam int WAKE_PULSE_CYC = WAKE_PULSE_MS * (CLK_HZ / 1000);
  localparam int WAKE_CNT_W     = 22;

  // ==========================================================
  // Register map (byte addresses)
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 32;
  localparam logic [4:0]  OFS_WAKE_CTRL = 5'h00;
  localparam logic [4:0]  OFS_EXT_CTRL  = 5'h04;
  localparam logic [4:0]  OFS_PM_CSR    = 5'h08;
  localparam logic [4:0]  OFS_STATUS    = 5'h0c;

  // Field positions
  localparam int WUC_AWE_BIT       = 0;
  localparam int EXT_INV0_BIT      = 0;
  localparam int EXT_INV1_BIT      = 1;
  localparam int PM_DSTATE_LSB     = 0;
  localparam int PM_PME_EN_BIT     = 8;
  localparam int PM_PME_STAT_BIT   = 15;
  localparam int STAT_AUX_BIT      = 0;
  localparam int STAT_PCIRST_BIT   = 1;
  localparam int STAT_WAKE_BIT     = 2;
  localparam int STAT_PME_BIT      = 3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    DST_D0U = 2'h0,
    DST_D1  = 2'h1,
    DST_D3  = 2'h2,
    DST_D0A = 2'h3
  } pmpl_dstate_t;

  localparam logic [1:0] PS_OFF  = 2'h0;
  localparam logic [1:0] PS_LINK = 2'h1;
  localparam logic [1:0] PS_FULL = 2'h3;

  typedef struct packed {
    logic         advanced_wake_enable;
    logic         state_bit1_invert;
    logic         state_bit0_invert;
    logic         pme_enable;
    logic         pme_status;
    pmpl_dstate_t dstate;
  } pmpl_regs_t;

  localparam pmpl_regs_t REGS_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, DST_D0U};

endpackage

/* File: rtl/pmpl_power_mgmt.sv */
// Power management pin logic: power-good hold, PME open drain, wake pulse,
// power state pins. Assumes all inputs but nrst synchronous to clk_sys, Avalon-MM master.
//
// Behaviour
// R1: Power-good low holds all logic in reset and floats PCI signals.
// R2: Wake event pulls PME low when PME enable or advanced wake enable set.
// R3: Wake packet with advanced wake enabled raises wake pulse for 50 ms.
// R4: Platform signals auxiliary power; then D3cold is supported and reported.
// R5: State pins: 00 low power no wake, 01 low power wake, 11 D0 active.
// R6: Upper state bit means full power, lower bit means link needed.
// R7: Each state pin polarity is inverted by its own invert bit.
// R8: PCI reset floats PCI outputs but PME keeps its wake context.
// R9: PME is only pulled low or released, never driven high.
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
module pmpl_power_mgmt
  import pmpl_pkg::*;
#(
  parameter int WAKE_PULSE_CYCLES = WAKE_PULSE_CYC
) (
  input  wire logic              clk_sys,              // System clock, 50 MHz
  input  wire logic              nrst,                 // Async reset, active low
  input  wire logic              board_power_good_in,  // Board power good
  input  wire logic              pci_rst_n_in,         // PCI reset, active low
  input  wire logic              aux_power_present_in, // Auxiliary power present
  input  wire logic              wake_event_in,        // Wakeup event pulse
  input  wire logic              wake_packet_in,       // Wake packet received pulse
  input  wire logic [ADDR_W-1:0] avs_address,          // Byte address
  input  wire logic              avs_read,             // Read request
  input  wire logic              avs_write,            // Write request
  input  wire logic [DATA_W-1:0] avs_writedata,        // Write data
  input  wire logic [3:0]        avs_byteenable,       // Byte enables
  output logic      [DATA_W-1:0] avs_readdata,         // Read data
  output logic                   avs_waitrequest,      // Wait request
  output logic                   pme_out,              // PME pin output value
  output logic                   pme_oe_n,             // PME drive enable, active low
  output logic                   wake_pulse_out,       // Wake pulse
  output logic      [1:0]        power_state_out,      // Encoded power state
  output logic                   pci_float_out,        // PCI pins to high impedance
  output logic                   core_reset_out        // Chip held in reset
);

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ==========================================================
  // Helpers
  function automatic logic [1:0] encode_state(input pmpl_regs_t r);
    logic [1:0] raw;
    raw = PS_OFF;
    if (r.dstate == DST_D0A) begin
      raw = PS_FULL;
    end else if (r.pme_enable || r.advanced_wake_enable) begin
      raw = PS_LINK;
    end
    return raw ^ {r.state_bit1_invert, r.state_bit0_invert};
  endfunction

  // ==========================================================
  // Registers and bus
  pmpl_regs_t              regs_reg, regs_next;
  logic                    wait_reg, wait_next;
  logic [DATA_W-1:0]       rdata_reg, rdata_next;
  logic [WAKE_CNT_W-1:0]   wcnt_reg, wcnt_next;
  logic                    wpulse_reg, wpulse_next;
  logic                    pme_drv_n_reg, pme_drv_n_next;
  logic [1:0]              pstate_reg, pstate_next;
  logic                    float_reg, float_next;
  logic                    hold_reg, hold_next;
  logic                    pg;
  logic                    wake_en;
  logic                    wr_go;
  logic                    rd_go;
  logic                    wake_load;
  logic                    pme_clear;

  assign pg        = board_power_good_in;
  assign wake_en   = regs_reg.pme_enable || regs_reg.advanced_wake_enable;
  assign wr_go     = avs_write && !wait_reg;
  assign rd_go     = avs_read && wait_reg;
  assign wake_load = wake_packet_in && regs_reg.advanced_wake_enable;
  assign pme_clear = wr_go && avs_address == OFS_PM_CSR && avs_byteenable[1]
                     && avs_writedata[PM_PME_STAT_BIT];

  always_comb begin
    regs_next   = regs_reg;
    wait_next   = 1'b1;
    rdata_next  = rdata_reg;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
    end
    if (rd_go) begin
      rdata_next = '0;
      unique case (avs_address)
        OFS_WAKE_CTRL: rdata_next[WUC_AWE_BIT] = regs_reg.advanced_wake_enable;
        OFS_EXT_CTRL: begin
          rdata_next[EXT_INV0_BIT] = regs_reg.state_bit0_invert;
          rdata_next[EXT_INV1_BIT] = regs_reg.state_bit1_invert;
        end
        OFS_PM_CSR: begin
          rdata_next[PM_DSTATE_LSB +: 2] = regs_reg.dstate;
          rdata_next[PM_PME_EN_BIT]      = regs_reg.pme_enable;
          rdata_next[PM_PME_STAT_BIT]    = regs_reg.pme_status;
        end
        OFS_STATUS: begin
          rdata_next[STAT_AUX_BIT]    = aux_power_present_in;   // R4
          rdata_next[STAT_PCIRST_BIT] = !pci_rst_n_in;
          rdata_next[STAT_WAKE_BIT]   = wpulse_reg;
          rdata_next[STAT_PME_BIT]    = !pme_drv_n_reg;
        end
        default: rdata_next = '0;
      endcase
    end
    if (wr_go) begin
      unique case (avs_address)
        OFS_WAKE_CTRL: begin
          if (avs_byteenable[0]) begin
            regs_next.advanced_wake_enable = avs_writedata[WUC_AWE_BIT];
          end
        end
        OFS_EXT_CTRL: begin
          if (avs_byteenable[0]) begin
            regs_next.state_bit0_invert = avs_writedata[EXT_INV0_BIT];
            regs_next.state_bit1_invert = avs_writedata[EXT_INV1_BIT];
          end
        end
        OFS_PM_CSR: begin
          if (avs_byteenable[0]) begin
            regs_next.dstate = pmpl_dstate_t'(avs_writedata[PM_DSTATE_LSB +: 2]);
          end
          if (avs_byteenable[1]) begin
            regs_next.pme_enable = avs_writedata[PM_PME_EN_BIT];
          end
        end
        default: ;
      endcase
    end
    if (pme_clear) begin
      regs_next.pme_status = 1'b0;
    end
    if (!pci_rst_n_in) begin
      regs_next.state_bit0_invert = 1'b0;                        // R8
      regs_next.state_bit1_invert = 1'b0;
      regs_next.dstate            = DST_D0U;
      if (!wake_en) begin
        regs_next.pme_status = 1'b0;                             // R8
      end
    end
    if (wake_event_in && wake_en) begin
      regs_next.pme_status = 1'b1;                               // R2
    end
    if (!pg) begin
      regs_next  = REGS_RST;                                     // R1
      wait_next  = 1'b1;
      rdata_next = '0;
    end
  end

  // ==========================================================
  // Pins
  always_comb begin
    wcnt_next = wcnt_reg;
    if (wake_load) begin
      wcnt_next = WAKE_CNT_W'(WAKE_PULSE_CYCLES);                // R3
    end else if (wcnt_reg != '0) begin
      wcnt_next = wcnt_reg - WAKE_CNT_W'(1);
    end
    if (!pg) begin
      wcnt_next = '0;                                            // R1
    end
    wpulse_next    = wcnt_next != '0;                            // R3
    pme_drv_n_next = !regs_next.pme_status;                      // R9
    pstate_next    = pg ? encode_state(regs_reg) : PS_OFF;       // R5 R6 R7
    float_next     = !pg || !pci_rst_n_in;                       // R1 R8
    hold_next      = !pg;                                        // R1
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regs_reg      <= REGS_RST;
      wait_reg      <= 1'b1;
      rdata_reg     <= '0;
      wcnt_reg      <= '0;
      wpulse_reg    <= 1'b0;
      pme_drv_n_reg <= 1'b1;
      pstate_reg    <= PS_OFF;
      float_reg     <= 1'b1;
      hold_reg      <= 1'b1;
    end else begin
      regs_reg      <= regs_next;
      wait_reg      <= wait_next;
      rdata_reg     <= rdata_next;
      wcnt_reg      <= wcnt_next;
      wpulse_reg    <= wpulse_next;
      pme_drv_n_reg <= pme_drv_n_next;
      pstate_reg    <= pstate_next;
      float_reg     <= float_next;
      hold_reg      <= hold_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign pme_out         = 1'b0;                                 // R9
  assign pme_oe_n        = pme_drv_n_reg;
  assign wake_pulse_out  = wpulse_reg;
  assign power_state_out = pstate_reg;
  assign pci_float_out   = float_reg;
  assign core_reset_out  = hold_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_pg_hold;
    !pg |=> pci_float_out && core_reset_out && pme_oe_n && !wake_pulse_out;
  endproperty
  a_pg_hold: assert property (p_pg_hold) else $error("power good low not held"); // R1

  property p_pme_set;
    pg && wake_event_in && wake_en |=> !pme_oe_n;
  endproperty
  a_pme_set: assert property (p_pme_set) else $error("PME not pulled low"); // R2

  property p_pme_cause;
    $fell(pme_oe_n) |-> $past(wake_event_in && wake_en);
  endproperty
  a_pme_cause: assert property (p_pme_cause) else $error("PME low without cause"); // R2

  sequence s_wake_start;
    pg && wake_load;
  endsequence
  sequence s_wake_hold;
    wake_pulse_out [*8];
  endsequence
  property p_wake_pulse;
    s_wake_start |=> wake_pulse_out && wcnt_reg == WAKE_CNT_W'(WAKE_PULSE_CYCLES);
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse not loaded"); // R3

  // Power good loss ends the pulse early, so it aborts the check
  property p_wake_run;
    disable iff (!rst_n || !pg) s_wake_start |=> s_wake_hold;
  endproperty
  a_wake_run: assert property (p_wake_run) else $error("wake pulse cut short"); // R3

  property p_wake_end;
    $fell(wake_pulse_out) && $past(pg) |-> $past(wcnt_reg) == WAKE_CNT_W'(1);
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("wake pulse ended early"); // R3

  property p_aux_read;
    avs_read && !avs_waitrequest && $past(avs_address) == OFS_STATUS && $past(pg)
      |-> avs_readdata[STAT_AUX_BIT] == $past(aux_power_present_in);
  endproperty
  a_aux_read: assert property (p_aux_read) else $error("aux power status wrong"); // R4

  property p_state_code;
    $past(pg) |-> power_state_out == $past(encode_state(regs_reg));
  endproperty
  a_state_code: assert property (p_state_code) else $error("power state code wrong"); // R5

  property p_state_full;
    pg && regs_reg.dstate == DST_D0A |=>
      power_state_out[1] != $past(regs_reg.state_bit1_invert);
  endproperty
  a_state_full: assert property (p_state_full) else $error("full power bit wrong"); // R6

  property p_state_link;
    pg && regs_reg.dstate != DST_D0A && wake_en |=>
      power_state_out[0] != $past(regs_reg.state_bit0_invert);
  endproperty
  a_state_link: assert property (p_state_link) else $error("link bit wrong"); // R6

  property p_invert;
    pg && $changed(regs_reg.state_bit0_invert) && $stable(regs_reg.dstate)
      && $stable(wake_en) |=> $changed(power_state_out[0]);
  endproperty
  a_invert: assert property (p_invert) else $error("state bit 0 not inverted"); // R7

  property p_pci_reset;
    pg && !pci_rst_n_in && regs_reg.pme_status && wake_en && !pme_clear
      |=> pci_float_out && !pme_oe_n;
  endproperty
  a_pci_reset: assert property (p_pci_reset) else $error("PME context lost"); // R8

  property p_pci_float;
    !pci_rst_n_in |=> pci_float_out;
  endproperty
  a_pci_float: assert property (p_pci_float) else $error("PCI pins not floated"); // R8

  property p_open_drain;
    !pme_oe_n |-> pme_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("PME driven high"); // R9

endmodule

/* File: sim/pmpl_host_model.sv */
// Host platform side: aux supply, wake sources and the PME pull-up.
// Assumes bench commands change just after a rising clk_sys edge.
`timescale 1ns/10ps
module pmpl_host_model (
  input  wire logic aux_avail,            // Aux supply exists
  input  wire logic ev_cmd,               // Raise a wake event
  input  wire logic pkt_cmd,              // Deliver a wake packet
  input  wire logic pme_out,              // Device PME value
  input  wire logic pme_oe_n,             // Device PME enable, active low
  output logic      aux_power_present_in, // Aux present to device
  output logic      wake_event_in,        // Wake event to device
  output logic      wake_packet_in,       // Wake packet to device
  output logic      pme_line              // Resolved PME wire
);
  assign aux_power_present_in = aux_avail;
  assign wake_event_in        = ev_cmd;
  assign wake_packet_in       = pkt_cmd;
  // Pull-up holds the wire high when released
  assign pme_line = pme_oe_n ? 1'b1 : pme_out;
endmodule

/* File: sim/tb_power_mgmt_pin_logic.sv */
// Self-checking bench of the power management pin logic.
// Assumes the host model beside it and a short wake pulse parameter.
`timescale 1ns/10ps
module tb_power_mgmt_pin_logic;
  import pmpl_pkg::*;
  `define CHK(a,b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
  typedef struct packed {logic [1:0] ds; logic pe, awe, i1, i0; logic [1:0] ps;} pmpl_row_t;
  localparam int PULSE = 20;
  localparam pmpl_row_t ROWS [8] = '{8'hc3, 8'h00, 8'h61, 8'h91, 8'h85, 8'hc9, 8'h7e, 8'hfc};
  logic        clk_sys, nrst, pg, prst_n, aux_avail, ev_cmd, pkt_cmd;
  logic [4:0]  avs_address;
  logic        avs_read, avs_write;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest, pme_out, pme_oe_n, wake_pulse_out, pci_float_out, core_reset_out;
  logic [1:0]  power_state_out;
  wire         aux_power_present_in, wake_event_in, wake_packet_in, pme_line;
  int          fail_count, n_checks;

  pmpl_power_mgmt #(.WAKE_PULSE_CYCLES(PULSE)) pmpl_power_mgmt_inst (
    .clk_sys(clk_sys), .nrst(nrst), .board_power_good_in(pg), .pci_rst_n_in(prst_n),
    .aux_power_present_in(aux_power_present_in), .wake_event_in(wake_event_in),
    .wake_packet_in(wake_packet_in), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pme_out(pme_out),
    .pme_oe_n(pme_oe_n), .wake_pulse_out(wake_pulse_out), .power_state_out(power_state_out),
    .pci_float_out(pci_float_out), .core_reset_out(core_reset_out));
  pmpl_host_model pmpl_host_model_inst (
    .aux_avail(aux_avail), .ev_cmd(ev_cmd), .pkt_cmd(pkt_cmd), .pme_out(pme_out),
    .pme_oe_n(pme_oe_n), .aux_power_present_in(aux_power_present_in),
    .wake_event_in(wake_event_in), .wake_packet_in(wake_packet_in), .pme_line(pme_line));

  always #10 clk_sys = ~clk_sys;

  // ==========================================================
  // Tasks
  task automatic tally_and_finish;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Outputs read right after an edge show their pre-edge values
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    if (i >= 50) begin
      fail_count++;
      tally_and_finish();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic pulse_in(input bit pkt);
    @(posedge clk_sys);
    if (pkt) pkt_cmd <= 1'b1;
    else ev_cmd <= 1'b1;
    @(posedge clk_sys);
    pkt_cmd <= 1'b0;
    ev_cmd <= 1'b0;
  endtask
  task automatic cnt_pulse(input int exp);
    int c;
    c = 0;
    pulse_in(1);
    repeat (40) begin
      @(posedge clk_sys);
      c += (wake_pulse_out === 1'b1);
    end
    `CHK(c, exp)
  endtask

  // ==========================================================
  // Sequence
  initial begin
    clk_sys = 0;
    nrst = 0;
    pg = 1;
    prst_n = 1;
    aux_avail = 0;
    ev_cmd = 0;
    pkt_cmd = 0;
    avs_address = 0;
    avs_read = 0;
    avs_write = 0;
    avs_writedata = 0;
    avs_byteenable = 4'hf;
    fail_count = 0;
    n_checks = 0;
    tick(3);
    nrst <= 1'b1;
    tick(4);
    `CHK(core_reset_out, 1'b0)
    `CHK(pci_float_out, 1'b0)
    `CHK(pme_line, 1'b1)
    `CHK(power_state_out, 2'h0)
    foreach (ROWS[k]) begin
      bus(1, OFS_WAKE_CTRL, {31'h0, ROWS[k].awe});
      bus(1, OFS_EXT_CTRL, {30'h0, ROWS[k].i1, ROWS[k].i0});
      bus(1, OFS_PM_CSR, {23'h0, ROWS[k].pe, 6'h0, ROWS[k].ds});
      tick(2);
      `CHK(power_state_out, ROWS[k].ps)
    end
    // Enables clear: wake sources ignored
    bus(1, OFS_WAKE_CTRL, 32'h0);
    bus(1, OFS_EXT_CTRL, 32'h0);
    bus(1, OFS_PM_CSR, 32'h0);
    pulse_in(0);
    tick(1);
    `CHK(pme_line, 1'b1)
    cnt_pulse(0);
    bus(1, OFS_PM_CSR, 32'h100);
    pulse_in(0);
    tick(1);
    `CHK(pme_line, 1'b0)
    `CHK(pme_out, 1'b0)
    bus(1, OFS_WAKE_CTRL, 32'h1);
    cnt_pulse(PULSE);
    bus(1, OFS_PM_CSR, 32'h8100);
    tick(2);
    `CHK(pme_line, 1'b1)
    // Advanced wake alone, then PCI reset keeps PME context
    bus(1, OFS_PM_CSR, 32'h0);
    bus(1, OFS_EXT_CTRL, 32'h3);
    pulse_in(0);
    tick(1);
    `CHK(pme_line, 1'b0)
    prst_n <= 1'b0;
    tick(3);
    `CHK(pci_float_out, 1'b1)
    `CHK(pme_line, 1'b0)
    prst_n <= 1'b1;
    tick(2);
    bus(0, OFS_EXT_CTRL, 32'h0);
    `CHK(q, 32'h0)
    bus(0, OFS_PM_CSR, 32'h0);
    `CHK(q, 32'h8000)
    for (int k = 0; k < 2; k++) begin
      aux_avail <= k[0];
      bus(0, OFS_STATUS, 32'h0);
      `CHK(q[STAT_AUX_BIT], k[0])
    end
    bus(1, 5'h10, 32'hffffffff);
    bus(0, 5'h10, 32'h0);
    `CHK(q, 32'h0)
    bus(0, OFS_WAKE_CTRL, 32'h0);
    `CHK(q, 32'h1)
    // Power good loss clears everything
    pg <= 1'b0;
    tick(3);
    `CHK(core_reset_out, 1'b1)
    `CHK(pci_float_out, 1'b1)
    `CHK(pme_line, 1'b1)
    `CHK(power_state_out, 2'h0)
    pg <= 1'b1;
    tick(2);
    bus(0, OFS_WAKE_CTRL, 32'h0);
    `CHK(q, 32'h0)
    // Mid-run reset clears registers and restarts the release
    bus(1, OFS_WAKE_CTRL, 32'h1);
    nrst <= 1'b0;
    tick(1);
    `CHK(core_reset_out, 1'b1)
    `CHK(power_state_out, 2'h0)
    nrst <= 1'b1;
    tick(4);
    `CHK(core_reset_out, 1'b0)
    bus(0, OFS_WAKE_CTRL, 32'h0);
    `CHK(q, 32'h0)
    tally_and_finish();
  end
endmodule
